/* File: pkg/asc_pkg.sv */
package asc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] ASC_STEP8_IDX = 8'h98;
  localparam logic [7:0] ASC_STEP9_IDX = 8'h99;
  localparam logic [7:0] ASC_STATUS_IDX = 8'hc0;

  // Reset values of the step configuration registers and the status register.
  localparam logic [15:0] ASC_STEP8_RST = 16'h0008;
  localparam logic [15:0] ASC_STEP9_RST = 16'h0009;
  localparam logic [15:0] ASC_STATUS_RST = 16'h0000;

  // Steps held by this block, entry 0 is step 8 and entry 1 is step 9.
  localparam int ASC_NUM_STEPS = 2;
  localparam int ASC_STEP_W = 1;
  localparam logic [ASC_NUM_STEPS-1:0][7:0] ASC_STEP_IDX =
    {ASC_STEP9_IDX, ASC_STEP8_IDX};
  localparam logic [ASC_NUM_STEPS-1:0][15:0] ASC_STEP_RST =
    {ASC_STEP9_RST, ASC_STEP8_RST};

  // Bus address layout.
  localparam int ASC_ADR_LO = 2;
  localparam int ASC_IDX_W = 8;

  // Step register fields; reserved bits 12:5 are outside the write mask.
  localparam int ASC_EN_BIT = 15;
  localparam int ASC_GAIN_LO = 13;
  localparam int ASC_NEG_BIT = 4;
  localparam int ASC_POS_LO = 0;
  localparam logic [15:0] ASC_WR_MASK = 16'he01f;

  // Gain codes.
  localparam logic [1:0] ASC_GAIN_X1 = 2'h0;
  localparam logic [1:0] ASC_GAIN_X2 = 2'h1;

  // Positive input codes.
  localparam logic [3:0] ASC_POS_EXT7 = 4'h7;
  localparam logic [3:0] ASC_POS_TEMP = 4'h8;
  localparam logic [3:0] ASC_POS_SHORT = 4'h9;
  localparam logic [3:0] ASC_POS_TDAC = 4'ha;
  localparam logic [3:0] ASC_POS_AVDD_MON = 4'he;
  localparam logic [3:0] ASC_POS_DVDD_MON = 4'hf;

  // Status register fields.
  localparam int ASC_ST_VALID = 0;
  localparam int ASC_ST_STEP = 1;
  localparam int ASC_ST_POS_LO = 4;
  localparam int ASC_ST_NEG_LO = 8;
  localparam int ASC_ST_GAIN_LO = 10;
  localparam int ASC_ST_PEND = 15;

  // Negative input source.
  typedef enum logic [1:0] {
    ASC_NEG_GND = 2'h0,
    ASC_NEG_EXT7 = 2'h1,
    ASC_NEG_AUTO = 2'h2
  } asc_neg_e;

  // Bus handshake states.
  typedef enum logic {
    ASC_BUS_IDLE = 1'b0,
    ASC_BUS_ACK = 1'b1
  } asc_bus_e;

endpackage : asc_pkg

/* File: hw/asc_step_reg.sv */
`timescale 1ns/100ps
module asc_step_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Write port.
  input wire logic writeStrobe,
  input wire logic [1:0] byteSel,
  input wire logic [15:0] writeData,
  // Stored value.
  output logic [15:0] value
);
  import asc_pkg::*;

  logic [15:0] value_reg;
  logic [15:0] value_next;

  // Merge enabled byte lanes, then clear reserved bits so they read zero.
  always_comb begin
    value_next = value_reg;
    if (writeStrobe) begin
      for (int b = 0; b < 2; b++) begin
        if (byteSel[b]) begin
          value_next[b*8 +: 8] = writeData[b*8 +: 8];
        end
      end
    end
    value_next = value_next & ASC_WR_MASK;
  end

  // Reset value is the step's own default configuration.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule : asc_step_reg

/* File: hw/asc_input_route.sv */
`timescale 1ns/100ps
module asc_input_route (
  // Step fields.
  input wire logic [3:0] posCode,
  input wire logic negSelect,
  input wire logic [1:0] gainCode,
  // Decoded routing.
  output logic [15:0] posOneHot,
  output asc_pkg::asc_neg_e negSource,
  output logic [1:0] gainShift
);
  import asc_pkg::*;

  logic internalSel;

  // One-hot index equals the code: 0..7 external inputs, 8 temperature,
  // 9 internal short, 10 test DAC, 11..13 supply monitors, 14 and 15
  // analog and digital supply divided by 103.
  assign posOneHot = 16'h0001 << posCode;

  // Every internal source, the unclear codes included, picks its own
  // negative input, so the select bit cannot short an internal node.
  assign internalSel = posCode > ASC_POS_EXT7;

  // Negative input routing.
  always_comb begin
    if (internalSel) begin
      negSource = ASC_NEG_AUTO;
    end else if (negSelect) begin
      negSource = ASC_NEG_EXT7;
    end else begin
      negSource = ASC_NEG_GND;
    end
  end

  // Gain as a shift: 1, 2, and 4 for both upper codes.
  always_comb begin
    unique case (gainCode)
      ASC_GAIN_X1: gainShift = 2'h0;
      ASC_GAIN_X2: gainShift = 2'h1;
      default: gainShift = 2'h2;
    endcase
  end

endmodule : asc_input_route

/* File: hw/asc_step_config.sv */
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
module asc_step_config (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Wishbone classic slave.
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Sequencer request.
  input wire logic seqLoad,
  input wire logic [asc_pkg::ASC_STEP_W-1:0] seqStep,
  // Settings of the step being converted.
  output logic actValid,
  output logic [asc_pkg::ASC_STEP_W-1:0] actStep,
  output logic [1:0] actGainShift,
  output logic [15:0] actPosSel,
  output asc_pkg::asc_neg_e actNeg
);
  import asc_pkg::*;

  asc_bus_e busState_reg;
  asc_bus_e busState_next;
  logic [31:0] readData_reg;
  logic [ASC_IDX_W-1:0] regIndex;
  logic upperZero;
  logic busReq;
  logic wrCommit;
  logic statusHit;
  logic statusWrite;
  logic [ASC_NUM_STEPS-1:0] stepHit;
  logic [ASC_NUM_STEPS-1:0] stepWrite;
  logic [ASC_NUM_STEPS-1:0] stepEnable;
  logic [15:0] stepValue [ASC_NUM_STEPS];
  logic [15:0] stepPos [ASC_NUM_STEPS];
  asc_neg_e stepNeg [ASC_NUM_STEPS];
  logic [1:0] stepGain [ASC_NUM_STEPS];
  logic [3:0] stepCode [ASC_NUM_STEPS];
  logic [15:0] stepRead;
  logic [15:0] statusWord;
  logic [31:0] readWord;

  // Active-step snapshot and the update flag.
  logic actValid_reg;
  logic [ASC_STEP_W-1:0] actStep_reg;
  logic [1:0] actGain_reg;
  logic [15:0] actPos_reg;
  asc_neg_e actNeg_reg;
  logic [3:0] actCode_reg;
  logic pending_reg;
  logic pending_next;
  logic pendSet;
  logic pendClr;

  // Address decode; bits above the index must be zero to hit anything.
  assign regIndex = wbAdr[ASC_ADR_LO +: ASC_IDX_W];
  assign upperZero = (wbAdr >> (ASC_ADR_LO + ASC_IDX_W)) == 32'h0;
  assign busReq = wbCyc & wbStb;
  assign wrCommit = busReq & wbWe & (busState_reg == ASC_BUS_ACK);
  assign statusHit = upperZero & (regIndex == ASC_STATUS_IDX);
  assign statusWrite = wrCommit & statusHit;

  // One register and one decoder per step.
  generate
    for (genvar g = 0; g < ASC_NUM_STEPS; g++) begin : gStep
      assign stepHit[g] = upperZero & (regIndex == ASC_STEP_IDX[g]);
      assign stepWrite[g] = wrCommit & stepHit[g];
      assign stepEnable[g] = stepValue[g][ASC_EN_BIT];
      assign stepCode[g] = stepValue[g][ASC_POS_LO +: 4];

      asc_step_reg #(
        .RESET_VALUE(ASC_STEP_RST[g])
      ) uReg (
        .clk(clk),
        .resetn(resetn),
        .writeStrobe(stepWrite[g]),
        .byteSel(wbSel[1:0]),
        .writeData(wbDatW[15:0]),
        .value(stepValue[g])
      );

      asc_input_route uRoute (
        .posCode(stepCode[g]),
        .negSelect(stepValue[g][ASC_NEG_BIT]),
        .gainCode(stepValue[g][ASC_GAIN_LO +: 2]),
        .posOneHot(stepPos[g]),
        .negSource(stepNeg[g]),
        .gainShift(stepGain[g])
      );
    end
  endgenerate

  // Read selection; an unmapped index reads as zero.
  always_comb begin
    stepRead = 16'h0000;
    for (int s = 0; s < ASC_NUM_STEPS; s++) begin
      if (stepHit[s]) begin
        stepRead = stepRead | stepValue[s];
      end
    end
  end

  // Status word assembly; unused bits read zero.
  always_comb begin
    statusWord = ASC_STATUS_RST;
    statusWord[ASC_ST_VALID] = actValid_reg;
    statusWord[ASC_ST_STEP +: ASC_STEP_W] = actStep_reg;
    statusWord[ASC_ST_POS_LO +: 4] = actCode_reg;
    statusWord[ASC_ST_NEG_LO +: 2] = actNeg_reg;
    statusWord[ASC_ST_GAIN_LO +: 2] = actGain_reg;
    statusWord[ASC_ST_PEND] = pending_reg;
  end

  assign readWord = {16'h0000, stepRead | (statusHit ? statusWord : 16'h0000)};

  // Bus handshake: one wait state, then a single-cycle acknowledge.
  always_comb begin
    unique case (busState_reg)
      ASC_BUS_IDLE: busState_next = busReq ? ASC_BUS_ACK : ASC_BUS_IDLE;
      ASC_BUS_ACK: busState_next = ASC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      busState_reg <= ASC_BUS_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  // Read data is captured as the acknowledge is raised, so it stands
  // stable for the whole acknowledge cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readData_reg <= 32'h0;
    end else if (busState_reg == ASC_BUS_IDLE && busReq) begin
      readData_reg <= readWord;
    end
  end

  assign wbAck = busState_reg == ASC_BUS_ACK;
  assign wbDatR = readData_reg;

  // The snapshot isolates the converter from register writes made during
  // a conversion; a disabled step loads as not valid and is skipped.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      actValid_reg <= 1'b0;
      actStep_reg <= '0;
      actGain_reg <= 2'h0;
      actPos_reg <= 16'h0000;
      actNeg_reg <= ASC_NEG_GND;
      actCode_reg <= 4'h0;
    end else if (seqLoad) begin
      actValid_reg <= stepEnable[seqStep];
      actStep_reg <= seqStep;
      actGain_reg <= stepGain[seqStep];
      actPos_reg <= stepPos[seqStep];
      actNeg_reg <= stepNeg[seqStep];
      actCode_reg <= stepCode[seqStep];
    end
  end

  // Update flag: set when software rewrites the step held in the snapshot,
  // cleared by writing one to it; a set in the same cycle wins.
  assign pendSet = stepWrite[actStep_reg];
  assign pendClr = statusWrite & wbSel[1] & wbDatW[ASC_ST_PEND];
  assign pending_next = pendSet | (pending_reg & ~pendClr);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  assign actValid = actValid_reg;
  assign actStep = actStep_reg;
  assign actGainShift = actGain_reg;
  assign actPosSel = actPos_reg;
  assign actNeg = actNeg_reg;

endmodule : asc_step_config

/* File: tb/asc_step_config_checker.sv */
`timescale 1ns/100ps
module asc_step_config_checker (
  // Bus side.
  input wire logic clk,
  input wire logic resetn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  // Sequencer side.
  input wire logic seqLoad,
  input wire logic [asc_pkg::ASC_STEP_W-1:0] seqStep,
  input wire logic actValid,
  input wire logic [asc_pkg::ASC_STEP_W-1:0] actStep,
  input wire logic [1:0] actGainShift,
  input wire logic [15:0] actPosSel,
  input wire asc_pkg::asc_neg_e actNeg
);
  import asc_pkg::*;
  // One domain, so reset masks every check unless a check says otherwise.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // A step register is hit only with the upper address bits clear.
  wire stepHit = wbAdr[31:10] == 22'h0 &&
    (wbAdr[9:2] == ASC_STEP8_IDX || wbAdr[9:2] == ASC_STEP9_IDX);
  sequence reqTaken;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence ackPulse;
    wbAck ##1 !wbAck;
  endsequence
  ack_one_wait_a: assert property (reqTaken |=> ackPulse)
    else $error("ack not one cycle after request");
  rsvd_read_zero_a: assert property (wbAck && !wbWe && stepHit |->
    wbDatR[31:16] == 16'h0 && wbDatR[12:5] == 8'h0)
    else $error("reserved bits read nonzero");
  load_step_a: assert property (seqLoad |=> actStep == $past(seqStep))
    else $error("loaded step index wrong");
  act_hold_a: assert property (!seqLoad |=> $stable({actValid,
    actStep, actGainShift, actPosSel, actNeg}))
    else $error("settings changed without load");
  gain_code_a: assert property (actGainShift != 2'h3)
    else $error("gain shift out of range");
  pos_onehot_a: assert property ($onehot0(actPosSel))
    else $error("positive select not one-hot");
  auto_neg_a: assert property (|actPosSel[15:8] |-> actNeg == ASC_NEG_AUTO)
    else $error("internal source without auto negative");
  ext_neg_a: assert property (|actPosSel[7:0] |-> actNeg != ASC_NEG_AUTO)
    else $error("external input with auto negative");
  reset_idle_a: assert property (disable iff (1'b0) !resetn |=>
    !wbAck && !actValid && actPosSel == 16'h0)
    else $error("outputs not idle after reset");
endmodule : asc_step_config_checker

/* File: tb/asc_step_config_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
module asc_step_config_tb_top;
  import asc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [31:0] wbAdr = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic seqLoad = 1'b0;
  logic [ASC_STEP_W-1:0] seqStep = 1'b0;
  logic actValid;
  logic [ASC_STEP_W-1:0] actStep;
  logic [1:0] actGainShift;
  logic [15:0] actPosSel;
  asc_neg_e actNeg;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  asc_step_config uut (.clk(clk), .resetn(resetn), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .seqLoad(seqLoad),
    .seqStep(seqStep), .actValid(actValid), .actStep(actStep),
    .actGainShift(actGainShift), .actPosSel(actPosSel), .actNeg(actNeg));
  // Free-running 25 MHz clock.
  initial forever #20 clk = ~clk;
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // Cut a hang short; the whole run needs well under this.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end
  // One classic cycle; the request is released once ack is seen, or after 50 cycles without it.
  task automatic xfer(input logic we, input logic [7:0] idx,
                      input logic [3:0] sel, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {22'h0, idx, 2'h0};
    wbSel <= sel;
    wbDatW <= {16'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    if (n >= 50) n_mismatch++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : xfer
  // One-cycle load pulse; results are sampled half a cycle later.
  task automatic load(input logic s);
    @(posedge clk);
    seqLoad <= 1'b1;
    seqStep <= s;
    @(posedge clk);
    seqLoad <= 1'b0;
    @(negedge clk);
  endtask : load
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    xfer(1'b0, ASC_STEP8_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00000008)
    xfer(1'b0, ASC_STEP9_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00000009)
    xfer(1'b0, 8'h10, 4'h3, 16'h0);
    `CHK(rd, 32'h0)
    $display("test reset_values done");
    xfer(1'b1, ASC_STEP8_IDX, 4'h3, 16'hffff);
    xfer(1'b0, ASC_STEP8_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h0000e01f)
    // Only the low byte lane is enabled, so bits 15:8 keep their reset.
    xfer(1'b1, ASC_STEP9_IDX, 4'h1, 16'hffff);
    xfer(1'b0, ASC_STEP9_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h0000001f)
    load(1'b1);
    `CHK(actStep, 1'b1)
    `CHK(actNeg, ASC_NEG_AUTO)
    $display("test reserved_bits done");
    for (int c = 0; c < 16; c++) begin
      logic [3:0] p;
      p = c[3:0];
      xfer(1'b1, ASC_STEP8_IDX, 4'h3, {p[0], p[1:0], 8'h00, p[2], p});
      load(1'b0);
      `CHK(actValid, p[0])
      `CHK(actGainShift, (p[1:0] == 2'h3) ? 2'h2 : p[1:0])
      `CHK(actPosSel, 16'h1 << p)
      `CHK(actNeg, p[3] ? ASC_NEG_AUTO : (p[2] ? ASC_NEG_EXT7 : ASC_NEG_GND))
    end
    $display("test input_codes done");
    // Step 8 holds e01f and is loaded, and the writes to it before that load raised the
    // update flag: valid, step 0, code f, automatic negative, gain 4.
    xfer(1'b0, ASC_STATUS_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00008af1)
    // The clear bit sits in the high lane, so a low-lane write keeps it.
    xfer(1'b1, ASC_STATUS_IDX, 4'h1, 16'h8000);
    xfer(1'b0, ASC_STATUS_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00008af1)
    xfer(1'b1, ASC_STATUS_IDX, 4'h2, 16'h8000);
    xfer(1'b0, ASC_STATUS_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00000af1)
    // A write to the step not held in the snapshot leaves the flag clear.
    xfer(1'b1, ASC_STEP9_IDX, 4'h3, 16'h0009);
    xfer(1'b0, ASC_STATUS_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00000af1)
    xfer(1'b1, ASC_STEP8_IDX, 4'h3, 16'he01f);
    xfer(1'b0, ASC_STATUS_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00008af1)
    $display("test update_flag done");
    // A second reset in mid-run must restore every default.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    xfer(1'b0, ASC_STEP8_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00000008)
    xfer(1'b0, ASC_STEP9_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h00000009)
    xfer(1'b0, ASC_STATUS_IDX, 4'h3, 16'h0);
    `CHK(rd, 32'h0)
    `CHK(actValid, 1'b0)
    `CHK(actPosSel, 16'h0)
    `CHK(actNeg, ASC_NEG_GND)
    load(1'b0);
    `CHK(actValid, 1'b0)
    `CHK(actGainShift, 2'h0)
    `CHK(actPosSel, 16'h0100)
    `CHK(actNeg, ASC_NEG_AUTO)
    $display("test mid_reset done");
    results();
  end
endmodule : asc_step_config_tb_top
bind asc_step_config asc_step_config_checker chk (.clk(clk),
  .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck), .seqLoad(seqLoad),
  .seqStep(seqStep), .actValid(actValid), .actStep(actStep),
  .actGainShift(actGainShift), .actPosSel(actPosSel), .actNeg(actNeg));
